// file: hw/ldc_pkg.sv
// package of constants, register map and state codes for the led driver host
package ldc_pkg;

    // controller registers on the wishbone side (byte addresses)
    localparam logic [3:0]  LDC_OFS_CTRL       = 4'h0;
    localparam logic [3:0]  LDC_OFS_CMD        = 4'h4;
    localparam logic [3:0]  LDC_OFS_STATUS     = 4'h8;

    // control register fields
    localparam int          LDC_CTRL_RUN_BIT   = 0;
    localparam int          LDC_CTRL_AD_LSB    = 1;
    localparam logic [2:0]  LDC_CTRL_RESET     = 3'h0;

    // command register fields
    localparam int          LDC_CMD_DATA_LSB   = 0;
    localparam int          LDC_CMD_PTR_LSB    = 8;
    localparam int          LDC_CMD_NEW_BIT    = 16;
    localparam int          LDC_CMD_STOP_BIT   = 17;
    localparam int          LDC_CMD_CLOSE_BIT  = 18;

    // status register fields
    localparam int          LDC_STAT_BUSY_BIT  = 0;
    localparam int          LDC_STAT_HOLD_BIT  = 1;
    localparam int          LDC_STAT_NACK_BIT  = 2;

    // target address layout: fixed high part, strap part, write bit
    localparam logic [4:0]  LDC_DEV_ADDR_HI    = 5'h0F;
    localparam logic        LDC_RW_WRITE       = 1'h0;

    // device register map, reached through pointer bytes
    localparam logic [7:0]  LDC_PTR_SHUTDOWN   = 8'h00;
    localparam logic [7:0]  LDC_PTR_BRIGHT     = 8'h01;
    localparam logic [7:0]  LDC_PTR_APPLY      = 8'h25;
    localparam logic [7:0]  LDC_PTR_CHCTRL     = 8'h26;
    localparam logic [7:0]  LDC_PTR_GATE       = 8'h4A;
    localparam logic [7:0]  LDC_PTR_RESET      = 8'h4F;
    localparam logic [7:0]  LDC_TRIGGER_VALUE  = 8'h00;
    localparam int          LDC_CHANNELS       = 36;

    // bus timing: one quarter of an scl period covers the longest low time
    localparam int          LDC_CLK_PERIOD_NS  = 100;
    localparam int          LDC_T_QUARTER_NS   = 1300;
    localparam int          LDC_QUARTER_CYC    =
        (LDC_T_QUARTER_NS + LDC_CLK_PERIOD_NS - 1) / LDC_CLK_PERIOD_NS;
    localparam logic [4:0]  LDC_QUARTER_LAST   = 5'(LDC_QUARTER_CYC - 1);

    // byte positions within one transfer
    localparam logic [1:0]  LDC_BYTE_ADDR      = 2'h0;
    localparam logic [1:0]  LDC_BYTE_PTR       = 2'h1;
    localparam logic [1:0]  LDC_BYTE_DATA      = 2'h2;

    typedef enum logic [5:0] {
        LDC_ST_IDLE  = 6'h01,
        LDC_ST_START = 6'h02,
        LDC_ST_BIT   = 6'h04,
        LDC_ST_ACK   = 6'h08,
        LDC_ST_STOP  = 6'h10,
        LDC_ST_HOLD  = 6'h20
    } ldc_state_type;

endpackage

// file: hw/ldc_host.sv
// i2c write master for the led driver, commanded over wishbone
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps

module ldc_host
    import ldc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             scl_o,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        sda_i,
    output logic             hw_shutdown_pin_n_o
);

    // bus slave state
    logic        ack_q,   ack_d;
    logic [31:0] dat_q,   dat_d;
    logic [2:0]  ctrl_q,  ctrl_d;

    // line engine state
    ldc_state_type state_q, state_d;
    logic [4:0]  div_q,   div_d;
    logic [1:0]  phase_q, phase_d;
    logic [2:0]  bitn_q,  bitn_d;
    logic [1:0]  bsel_q,  bsel_d;
    logic [7:0]  shift_q, shift_d;
    logic        scl_q,   scl_d;
    logic        sdaoe_q, sdaoe_d;
    logic        ackok_q, ackok_d;
    logic        nack_q,  nack_d;
    logic        pend_q,  pend_d;
    logic        stop_q,  stop_d;
    logic        close_q, close_d;
    logic        new_q,   new_d;
    logic [7:0]  ptr_q,   ptr_d;
    logic [7:0]  data_q,  data_d;
    logic        sda_s1_q;
    logic        sda_s2_q;

    logic        access;
    logic        cmd_wr;
    logic        stat_clr;
    logic        accept;
    logic        tick;
    logic [7:0]  addr_byte;

    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    assign cmd_wr = access && wb_we_i && (wb_adr_i == LDC_OFS_CMD)
                    && (wb_sel_i[2:0] == 3'h7);
    assign stat_clr = access && wb_we_i && (wb_adr_i == LDC_OFS_STATUS)
                      && wb_sel_i[0] && wb_dat_i[LDC_STAT_NACK_BIT];
    // a command is only taken while the line sits idle or held open
    assign accept = cmd_wr && !pend_q
                    && (state_q == LDC_ST_IDLE || state_q == LDC_ST_HOLD);
    assign tick = (div_q == LDC_QUARTER_LAST);
    // strap value in ctrl must match how the device's select pin is tied
    assign addr_byte = {LDC_DEV_ADDR_HI,
                        ctrl_q[LDC_CTRL_AD_LSB +: 2], LDC_RW_WRITE};

    // wishbone slave: answer one cycle after the request, drop after one
    always_comb
    begin
        ack_d  = access;
        dat_d  = dat_q;
        ctrl_d = ctrl_q;
        if (access)
        begin
            dat_d = 32'h0000_0000;
            if (!wb_we_i)
            begin
                case (wb_adr_i)
                    LDC_OFS_CTRL:
                        dat_d[2:0] = ctrl_q;
                    LDC_OFS_STATUS:
                    begin
                        dat_d[LDC_STAT_BUSY_BIT] = pend_q
                            || (state_q != LDC_ST_IDLE
                                && state_q != LDC_ST_HOLD);
                        dat_d[LDC_STAT_HOLD_BIT] =
                            (state_q == LDC_ST_HOLD) && !pend_q;
                        dat_d[LDC_STAT_NACK_BIT] = nack_q;
                    end
                    default:
                        dat_d = 32'h0000_0000;
                endcase
            end
            else if (wb_adr_i == LDC_OFS_CTRL && wb_sel_i[0])
            begin
                ctrl_d = wb_dat_i[2:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            dat_q  <= 32'h0000_0000;
            ctrl_q <= LDC_CTRL_RESET;
        end
        else
        begin
            ack_q  <= ack_d;
            dat_q  <= dat_d;
            ctrl_q <= ctrl_d;
        end
    end

    // line engine: four quarter phases per scl bit, moves on tick except when leaving idle or hold
    always_comb
    begin
        state_d = state_q;
        div_d   = tick ? 5'h00 : div_q + 5'h01;
        phase_d = phase_q;
        bitn_d  = bitn_q;
        bsel_d  = bsel_q;
        shift_d = shift_q;
        scl_d   = scl_q;
        sdaoe_d = sdaoe_q;
        ackok_d = ackok_q;
        nack_d  = nack_q;
        pend_d  = pend_q;
        stop_d  = stop_q;
        close_d = close_q;
        new_d   = new_q;
        ptr_d   = ptr_q;
        data_d  = data_q;
        if (stat_clr)
        begin
            nack_d = 1'b0;
        end
        if (accept)
        begin
            pend_d  = 1'b1;
            data_d  = wb_dat_i[LDC_CMD_DATA_LSB +: 8];
            ptr_d   = wb_dat_i[LDC_CMD_PTR_LSB +: 8];
            stop_d  = wb_dat_i[LDC_CMD_STOP_BIT];
            close_d = wb_dat_i[LDC_CMD_CLOSE_BIT];
            // an idle bus always needs a fresh start and pointer
            new_d   = wb_dat_i[LDC_CMD_NEW_BIT] || state_q == LDC_ST_IDLE;
        end
        case (state_q)
            LDC_ST_IDLE, LDC_ST_HOLD:
            begin
                phase_d = 2'h0;
                if (pend_q)
                begin
                    pend_d = 1'b0;
                    bitn_d = 3'h0;
                    if (close_q)
                    begin
                        state_d = LDC_ST_STOP;
                    end
                    else if (new_q)
                    begin
                        // repeated start from hold also reloads the pointer
                        state_d = LDC_ST_START;
                        bsel_d  = LDC_BYTE_ADDR;
                        shift_d = addr_byte;
                    end
                    else
                    begin
                        state_d = LDC_ST_BIT;
                        bsel_d  = LDC_BYTE_DATA;
                        shift_d = data_q;
                    end
                end
            end
            LDC_ST_START:
            begin
                if (tick)
                begin
                    phase_d = phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaoe_d = 1'b0;
                        2'h1: scl_d   = 1'b1;
                        2'h2: sdaoe_d = 1'b1;
                        default:
                        begin
                            scl_d   = 1'b0;
                            state_d = LDC_ST_BIT;
                        end
                    endcase
                end
            end
            LDC_ST_BIT:
            begin
                if (tick)
                begin
                    phase_d = phase_q + 2'h1;
                    case (phase_q)
                        // data changes only while scl is low
                        2'h0: sdaoe_d = !shift_q[7];
                        2'h1: scl_d   = 1'b1;
                        2'h2: scl_d   = 1'b1;
                        default:
                        begin
                            scl_d   = 1'b0;
                            shift_d = {shift_q[6:0], 1'b0};
                            bitn_d  = bitn_q + 3'h1;
                            if (bitn_q == 3'h7)
                            begin
                                state_d = LDC_ST_ACK;
                            end
                        end
                    endcase
                end
            end
            LDC_ST_ACK:
            begin
                if (tick)
                begin
                    phase_d = phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaoe_d = 1'b0;
                        2'h1: scl_d   = 1'b1;
                        2'h2: ackok_d = !sda_s2_q;
                        default:
                        begin
                            scl_d  = 1'b0;
                            bitn_d = 3'h0;
                            if (!ackok_q)
                            begin
                                // set wins over a clear in the same cycle
                                nack_d  = 1'b1;
                                state_d = LDC_ST_STOP;
                            end
                            else if (bsel_q == LDC_BYTE_ADDR)
                            begin
                                state_d = LDC_ST_BIT;
                                bsel_d  = LDC_BYTE_PTR;
                                shift_d = ptr_q;
                            end
                            else if (bsel_q == LDC_BYTE_PTR)
                            begin
                                state_d = LDC_ST_BIT;
                                bsel_d  = LDC_BYTE_DATA;
                                shift_d = data_q;
                            end
                            else if (stop_q)
                            begin
                                state_d = LDC_ST_STOP;
                            end
                            else
                            begin
                                // bus stays open so the next byte lands
                                // at the stepped pointer
                                state_d = LDC_ST_HOLD;
                            end
                        end
                    endcase
                end
            end
            LDC_ST_STOP:
            begin
                if (tick)
                begin
                    phase_d = phase_q + 2'h1;
                    case (phase_q)
                        2'h0: sdaoe_d = 1'b1;
                        2'h1: scl_d   = 1'b1;
                        2'h2: sdaoe_d = 1'b0;
                        default:
                        begin
                            state_d = LDC_ST_IDLE;
                        end
                    endcase
                end
            end
            default:
            begin
                state_d = LDC_ST_IDLE;
                scl_d   = 1'b1;
                sdaoe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q  <= LDC_ST_IDLE;
            div_q    <= 5'h00;
            phase_q  <= 2'h0;
            bitn_q   <= 3'h0;
            bsel_q   <= LDC_BYTE_ADDR;
            shift_q  <= 8'h00;
            scl_q    <= 1'b1;
            sdaoe_q  <= 1'b0;
            ackok_q  <= 1'b0;
            nack_q   <= 1'b0;
            pend_q   <= 1'b0;
            stop_q   <= 1'b0;
            close_q  <= 1'b0;
            new_q    <= 1'b0;
            ptr_q    <= 8'h00;
            data_q   <= 8'h00;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            div_q    <= div_d;
            phase_q  <= phase_d;
            bitn_q   <= bitn_d;
            bsel_q   <= bsel_d;
            shift_q  <= shift_d;
            scl_q    <= scl_d;
            sdaoe_q  <= sdaoe_d;
            ackok_q  <= ackok_d;
            nack_q   <= nack_d;
            pend_q   <= pend_d;
            stop_q   <= stop_d;
            close_q  <= close_d;
            new_q    <= new_d;
            ptr_q    <= ptr_d;
            data_q   <= data_d;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign scl_o    = scl_q;
    // open drain: only ever pull low
    assign sda_o    = 1'b0;
    assign sda_oe_o = sdaoe_q;
    // pin low at reset keeps the device off until software releases it
    assign hw_shutdown_pin_n_o = ctrl_q[LDC_CTRL_RUN_BIT];

endmodule

// file: testbench/ldc_host_props.sv
// port checker for the led driver i2c host
`timescale 1ns/100ps
module ldc_host_props
    import ldc_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic       wb_ack_o,
    input wire logic       scl_o,
    input wire logic       sda_oe_o,
    input wire logic       hw_shutdown_pin_n_o
);
    logic [5:0] hi_q;
    wire        req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        ctrl_wr = req && wb_we_i && wb_adr_i == LDC_OFS_CTRL;
    // saturates so a long idle high time cannot wrap
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !scl_o)
            hi_q <= 6'h00;
        else if (hi_q != 6'h3F)
            hi_q <= hi_q + 6'h01;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_reset_idle: assert property ($fell(rst_i) |->
        scl_o && !sda_oe_o && !hw_shutdown_pin_n_o)
        else $error("bus or pin not idle after reset");
    chk_pin_cause: assert property ($changed(hw_shutdown_pin_n_o) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("shutdown pin moved without control write");
    chk_scl_high: assert property ($fell(scl_o) |-> hi_q >= 6'h1A)
        else $error("scl high shorter than 26 cycles");
    chk_sda_stable: assert property ($changed(sda_oe_o) && scl_o |->
        $past(scl_o) && $past(scl_o, 8))
        else $error("sda moved at or near scl rise");
    chk_start_hold: assert property (scl_o && $rose(sda_oe_o) |->
        scl_o [*8] ##[1:10] !scl_o)
        else $error("start not followed by scl fall in time");
    chk_stop_idle: assert property (scl_o && $past(scl_o)
        && $fell(sda_oe_o) |-> (scl_o && !sda_oe_o) [*8])
        else $error("bus not left idle after stop");
    cover property (scl_o && $rose(sda_oe_o));
    cover property (scl_o && $fell(sda_oe_o));
    cover property ($rose(hw_shutdown_pin_n_o));
endmodule

// file: testbench/ldc_dev_model.sv
// behavioural led driver target on the i2c wires
`timescale 1ns/100ps
module ldc_dev_model
(
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [1:0] strap_i,
    input  wire logic       pin_n_i,
    output logic            pull_o = 1'b0,
    output logic            lit_o
);
    logic [7:0] sr, ptr, shut, gate;
    logic [7:0] bri_sh [36], bri [36], ctl_sh [36], ctl [36];
    logic       act = 1'b0, ackp = 1'b0;
    int         nbit, nbyte;
    assign lit_o = pin_n_i && shut[0] && !gate[0];
    task automatic defaults;
        shut = 8'h00;
        gate = 8'h00;
        bri_sh = '{default: 8'h00};
        bri = '{default: 8'h00};
        ctl_sh = '{default: 8'h00};
        ctl = '{default: 8'h00};
    endtask
    // unmapped pointers and non-zero triggers fall through untouched
    task automatic store(input logic [7:0] p, input logic [7:0] d);
        if (p == 8'h00)
            shut = d;
        else if (p <= 8'h24)
            bri_sh[p - 8'h01] = d;
        else if (p >= 8'h26 && p <= 8'h49)
            ctl_sh[p - 8'h26] = d;
        else if (p == 8'h4A)
            gate = d;
        else if (p == 8'h25 && d == 8'h00)
        begin
            bri = bri_sh;
            ctl = ctl_sh;
        end
        else if (p == 8'h4F && d == 8'h00)
            defaults();
    endtask
    initial
        defaults();
    always @(negedge sda_i)
        if (scl_i)
        begin
            act = 1'b1;
            nbit = 0;
            nbyte = 0;
        end
    always @(posedge sda_i)
        if (scl_i)
            act = 1'b0;
    always @(posedge scl_i)
        if (act && !ackp)
        begin
            sr = {sr[6:0], sda_i};
            nbit++;
        end
    always @(negedge scl_i)
        if (ackp)
        begin
            ackp = 1'b0;
            pull_o <= 1'b0;
        end
        else if (act && nbit == 8)
        begin
            nbit = 0;
            if (nbyte == 0)
                act = sr == {5'h0F, strap_i, 1'b0};
            else if (nbyte == 1)
                ptr = sr;
            else
            begin
                store(ptr, sr);
                ptr = ptr + 8'h01;
            end
            nbyte++;
            ackp = act;
            pull_o <= act;
        end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the led driver i2c host
`timescale 1ns/100ps
module testbench;
    import ldc_pkg::*;
    localparam logic [2:0] MORE = 3'h0, NEW = 3'h1, LAST = 3'h2;
    localparam logic [2:0] ONE = 3'h3, CLOSE = 3'h4;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic        ack, scl, sda_o, sda_oe, pin_n, pull, lit;
    // the host's data value only reaches the wire while it enables it
    wire         sda_w = (sda_oe ? sda_o : 1'b1) && !pull;
    int          n_errors = 0, checks = 0;
    ldc_host ldc_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .scl_o(scl),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .sda_i(sda_w),
        .hw_shutdown_pin_n_o(pin_n));
    ldc_dev_model ldc_dev_model_i (.scl_i(scl), .sda_i(sda_w),
        .strap_i(2'h2), .pin_n_i(pin_n), .pull_o(pull), .lit_o(lit));
    initial
        forever #50 clk_i = ~clk_i;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // no answer time is assumed; only the watchdog ends a stuck wait
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic send(input logic [7:0] p, input logic [7:0] d,
                        input logic [2:0] f);
        wb(1'b1, LDC_OFS_CMD, {13'h0, f, p, d});
        do
            wb(1'b0, LDC_OFS_STATUS, 32'h0);
        while (rdat[LDC_STAT_BUSY_BIT] !== 1'b0);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("pin", pin_n, 32'h0);
        wb(1'b0, 4'hC, 32'h0);
        check("unmapped", rdat, 32'h0);
        wb(1'b1, LDC_OFS_CTRL, 32'h5);
        check("pin", pin_n, 32'h1);
        wb(1'b0, LDC_OFS_CTRL, 32'h0);
        check("ctrl", rdat, 32'h5);
        check("lit", lit, 32'h0);
        send(8'h00, 8'h01, ONE);
        check("lit", lit, 32'h1);
        send(8'h01, 8'h03, NEW);
        for (int i = 1; i < 36; i++)
            send(8'h00, 8'(i * 7 + 3), i == 35 ? LAST : MORE);
        check("shadow", ldc_dev_model_i.bri_sh[35], 32'hF8);
        check("active", ldc_dev_model_i.bri[35], 32'h0);
        send(8'h26, 8'h07, NEW);
        check("hold", rdat[LDC_STAT_HOLD_BIT], 32'h1);
        send(8'h00, 8'h00, CLOSE);
        check("hold", rdat[LDC_STAT_HOLD_BIT], 32'h0);
        check("ctl", ldc_dev_model_i.ctl_sh[0], 32'h7);
        send(8'h25, 8'h01, ONE);
        check("active", ldc_dev_model_i.bri[35], 32'h0);
        send(8'h25, 8'h00, ONE);
        check("active", ldc_dev_model_i.bri[35], 32'hF8);
        check("ctl", ldc_dev_model_i.ctl[0], 32'h7);
        send(8'h4A, 8'h01, ONE);
        check("lit", lit, 32'h0);
        send(8'h60, 8'hFF, ONE);
        check("nack", rdat[LDC_STAT_NACK_BIT], 32'h0);
        wb(1'b1, LDC_OFS_CTRL, 32'h3);
        send(8'h4A, 8'h00, ONE);
        check("nack", rdat[LDC_STAT_NACK_BIT], 32'h1);
        check("gate", ldc_dev_model_i.gate, 32'h1);
        wb(1'b1, LDC_OFS_STATUS, 32'h4);
        wb(1'b1, LDC_OFS_CTRL, 32'h5);
        wb(1'b0, LDC_OFS_STATUS, 32'h0);
        check("status", rdat, 32'h0);
        send(8'h4A, 8'h00, NEW);
        send(8'h4F, 8'h00, ONE);
        check("shut", ldc_dev_model_i.shut, 32'h0);
        check("ctl", ldc_dev_model_i.ctl[0], 32'h0);
        wb(1'b1, LDC_OFS_CTRL, 32'h4);
        check("pin", pin_n, 32'h0);
        // reset in mid-transfer must leave the bus idle and the pin low
        wb(1'b1, LDC_OFS_CTRL, 32'h5);
        wb(1'b1, LDC_OFS_CMD, {13'h0, ONE, 8'h00, 8'h01});
        repeat (100) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("pin", pin_n, 32'h0);
        check("scl", scl, 32'h1);
        check("sda", sda_oe, 32'h0);
        wb(1'b0, LDC_OFS_STATUS, 32'h0);
        check("status", rdat, 32'h0);
        tally_and_finish();
    end
    initial
    begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule

bind ldc_host ldc_host_props ldc_host_props_i (.*);
